// >>> hw/swt_params.svh
// Register offsets, field positions, reset values and timing counts of the wakeup timer
`ifndef SWT_PARAMS_SVH
`define SWT_PARAMS_SVH

// =====================================================================
// Register byte offsets
`define SWT_OFF_PORT_A      8'h00
`define SWT_OFF_KBD_SC      8'h04
`define SWT_OFF_KBD_EN      8'h08
`define SWT_OFF_MODE        8'h0C
`define SWT_OFF_STATUS      8'h10
`define SWT_OFF_CFG2        8'h78
`define SWT_OFF_CFG1        8'h7C
`define SWT_CFG2_INDEX      16'h001E
`define SWT_CFG1_INDEX      16'h001F

// =====================================================================
// Field positions
`define SWT_PA_WAKE_BIT     6
`define SWT_SC_PEND_BIT     3
`define SWT_SC_ACK_BIT      2
`define SWT_SC_MASK_BIT     1
`define SWT_EN_WAKE_BIT     6
`define SWT_CFG2_KEEP_BIT   1
`define SWT_CFG2_RSTPIN_BIT 0
`define SWT_CFG1_PERIOD_BIT 7
`define SWT_CFG1_SREC_BIT   3
`define SWT_MODE_STOP_BIT   0
`define SWT_MODE_WAIT_BIT   1
`define SWT_MODE_POR_BIT    2

// =====================================================================
// Reset values and masks
`define SWT_CFG_RESET       8'h00
`define SWT_PA_PIN_MASK     8'hBF
`define SWT_SC_RD_MASK      8'h0F

// =====================================================================
// Counts: wakeup periods in wake clock ticks, watchdog and recovery counts in clock cycles
`define SWT_WAKE_SHORT      16'h0200
`define SWT_WAKE_LONG       16'h4000
`define SWT_WDOG_SHORT      32'h0000_1FF0
`define SWT_WDOG_LONG       32'h0003_FFF0
`define SWT_REC_SHORT       16'h0020
`define SWT_REC_LONG        16'h1000

`endif

// >>> hw/swt_pkg.sv
// Types shared by the wakeup timer design
package swt_pkg;
  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } swt_wb_req_type;

  typedef enum logic [1:0] {
    SWT_RUN,
    SWT_STOP,
    SWT_RECOVER
  } swt_state_type;
endpackage : swt_pkg

// >>> hw/swt_wakeup_timer.sv
// Stop-mode periodic wakeup timer with keypad status logic and write-once configuration
//
// Register access over Wishbone and the address map were decided locally.
`include "swt_params.svh"
`timescale 1ns/1ps
`default_nettype none

module swt_wakeup_timer
  import swt_pkg::*;
#(
  parameter int WAKE_W = 16,
  parameter int WDOG_W = 32
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Device context
  input  wire logic        stop_mode,
  input  wire logic        wait_mode,
  input  wire logic        power_on_reset,
  input  wire logic        wake_rc_oscillator,
  input  wire logic        doubled_bus_clock,
  input  wire logic        keypad_pin_request,
  input  wire logic        watchdog_service,
  input  wire logic [7:0]  port_a_pins,
  // Outputs toward the processor
  output logic             keypad_irq,
  output logic             stop_wake,
  output logic             main_clock_off,
  output logic             recovery_done,
  output logic             watchdog_timeout,
  output logic             wake_clock_select
);

  // ===================================================================
  // Bus decode
  swt_wb_req_type req;
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                 sel: wb_sel_i, dat: wb_dat_i};

  wire logic access   = req.cyc && req.stb && !wb_ack_o;
  wire logic wr_lane0 = access && req.we && req.sel[0];
  wire logic hit_pa   = (req.adr == `SWT_OFF_PORT_A);
  wire logic hit_sc   = (req.adr == `SWT_OFF_KBD_SC);
  wire logic hit_en   = (req.adr == `SWT_OFF_KBD_EN);
  wire logic hit_md   = (req.adr == `SWT_OFF_MODE);
  wire logic hit_st   = (req.adr == `SWT_OFF_STATUS);
  wire logic hit_c2   = (req.adr == `SWT_OFF_CFG2);
  wire logic hit_c1   = (req.adr == `SWT_OFF_CFG1);

  // ===================================================================
  // Register state
  logic             wake_request_latch_reg;
  logic             pin_pending_reg;
  logic             irq_mask_reg;
  logic             wake_irq_enable_reg;
  logic [7:0]       cfg1_reg;
  logic [7:0]       cfg2_reg;
  logic             cfg1_locked_reg;
  logic             cfg2_locked_reg;
  logic             stop_prev_reg;
  logic             tick_prev_reg;
  logic [WAKE_W-1:0] wake_cnt_reg;
  logic [WAKE_W-1:0] rec_cnt_reg;
  logic [WDOG_W-1:0] wdog_cnt_reg;
  swt_state_type    state_reg;

  // ===================================================================
  // Configuration fields
  wire logic osc_keep_in_stop      = cfg2_reg[`SWT_CFG2_KEEP_BIT];
  wire logic period_select         = cfg1_reg[`SWT_CFG1_PERIOD_BIT];
  wire logic short_recovery_select = cfg1_reg[`SWT_CFG1_SREC_BIT];

  // ===================================================================
  // Wakeup generator
  wire logic stop_entry = stop_mode && !stop_prev_reg;
  wire logic src_clock  = osc_keep_in_stop ? doubled_bus_clock : wake_rc_oscillator;
  wire logic tick       = src_clock && !tick_prev_reg;
  wire logic gen_active = stop_mode && !wait_mode && wake_irq_enable_reg;
  wire logic [WAKE_W-1:0] wake_limit = period_select ? WAKE_W'(`SWT_WAKE_SHORT)
                                                     : WAKE_W'(`SWT_WAKE_LONG);
  wire logic overflow   = gen_active && tick && (wake_cnt_reg == wake_limit - 1'b1);

  wire logic [WAKE_W-1:0] wake_cnt_next =
    (stop_entry || !gen_active) ? '0 :
    overflow ? '0 : (tick ? wake_cnt_reg + 1'b1 : wake_cnt_reg);

  // ===================================================================
  // Keypad status and acknowledge
  wire logic ack_write = wr_lane0 && hit_sc && req.dat[`SWT_SC_ACK_BIT];
  wire logic set_wake  = overflow && wake_irq_enable_reg;
  wire logic wake_request_latch_next = set_wake ? 1'b1 :
                                       (ack_write ? 1'b0 : wake_request_latch_reg);
  wire logic pin_pending_next = keypad_pin_request ? 1'b1 :
                                (ack_write ? 1'b0 : pin_pending_reg);
  wire logic pending_flag = wake_request_latch_reg || pin_pending_reg;
  wire logic irq_next = pending_flag && !irq_mask_reg;

  // ===================================================================
  // Stop recovery and watchdog
  wire logic [WAKE_W-1:0] rec_limit = short_recovery_select ? WAKE_W'(`SWT_REC_SHORT)
                                                            : WAKE_W'(`SWT_REC_LONG);
  wire logic [WDOG_W-1:0] wdog_limit = period_select ? WDOG_W'(`SWT_WDOG_SHORT)
                                                     : WDOG_W'(`SWT_WDOG_LONG);
  wire logic wdog_clear = stop_mode || watchdog_service;

  swt_state_type state_next;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SWT_RUN: begin
        if (stop_mode) begin
          state_next = SWT_STOP;
        end
      end
      SWT_STOP: begin
        if (stop_mode && irq_next) begin
          state_next = SWT_RECOVER;
        end else if (!stop_mode) begin
          state_next = SWT_RUN;
        end
      end
      SWT_RECOVER: begin
        if (rec_cnt_reg == rec_limit - 1'b1) begin
          state_next = SWT_RUN;
        end
      end
      default: begin
        state_next = SWT_RUN;
      end
    endcase
  end

  // ===================================================================
  // Read data
  wire logic [7:0] pa_rd = (port_a_pins & `SWT_PA_PIN_MASK)
                           | (8'(wake_request_latch_reg) << `SWT_PA_WAKE_BIT);
  wire logic [7:0] sc_rd = ((8'(pending_flag) << `SWT_SC_PEND_BIT)
                           | (8'(irq_mask_reg) << `SWT_SC_MASK_BIT)) & `SWT_SC_RD_MASK;
  wire logic [7:0] en_rd = 8'(wake_irq_enable_reg) << `SWT_EN_WAKE_BIT;
  wire logic [7:0] md_rd = (8'(stop_mode) << `SWT_MODE_STOP_BIT)
                           | (8'(wait_mode) << `SWT_MODE_WAIT_BIT)
                           | (8'(power_on_reset) << `SWT_MODE_POR_BIT);
  wire logic [7:0] st_rd = {6'h00, cfg2_locked_reg, cfg1_locked_reg};
  wire logic [7:0] rd_byte = hit_pa ? pa_rd : hit_sc ? sc_rd : hit_en ? en_rd :
                             hit_md ? md_rd : hit_st ? st_rd : hit_c2 ? cfg2_reg :
                             hit_c1 ? cfg1_reg : 8'h00;

  // ===================================================================
  // Configuration write-once
  wire logic c2_write = wr_lane0 && hit_c2 && !cfg2_locked_reg;
  wire logic c1_write = wr_lane0 && hit_c1 && !cfg1_locked_reg;

  // ===================================================================
  // Sequential logic
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o               <= 1'b0;
      wb_dat_o               <= 32'h0000_0000;
      wake_request_latch_reg <= 1'b0;
      pin_pending_reg        <= 1'b0;
      irq_mask_reg           <= 1'b0;
      wake_irq_enable_reg    <= 1'b0;
      cfg1_reg               <= `SWT_CFG_RESET;
      cfg1_locked_reg        <= 1'b0;
      cfg2_locked_reg        <= 1'b0;
      stop_prev_reg          <= 1'b0;
      tick_prev_reg          <= 1'b0;
      wake_cnt_reg           <= '0;
      rec_cnt_reg            <= '0;
      wdog_cnt_reg           <= '0;
      state_reg              <= SWT_RUN;
      keypad_irq             <= 1'b0;
      stop_wake              <= 1'b0;
      main_clock_off         <= 1'b0;
      recovery_done          <= 1'b0;
      watchdog_timeout       <= 1'b0;
      wake_clock_select      <= 1'b0;
    end else begin
      wb_ack_o               <= access;
      wb_dat_o               <= {24'h00_0000, rd_byte};
      wake_request_latch_reg <= wake_request_latch_next;
      pin_pending_reg        <= pin_pending_next;
      stop_prev_reg          <= stop_mode;
      tick_prev_reg          <= src_clock;
      wake_cnt_reg           <= wake_cnt_next;
      state_reg              <= state_next;
      if (wr_lane0 && hit_sc) begin
        irq_mask_reg <= req.dat[`SWT_SC_MASK_BIT];
      end
      if (wr_lane0 && hit_en) begin
        wake_irq_enable_reg <= req.dat[`SWT_EN_WAKE_BIT];
      end
      if (c1_write) begin
        cfg1_reg        <= req.dat[7:0];
        cfg1_locked_reg <= 1'b1;
      end
      if (c2_write) begin
        cfg2_locked_reg <= 1'b1;
      end
      rec_cnt_reg <= (state_reg == SWT_RECOVER) ? rec_cnt_reg + 1'b1 : '0;
      wdog_cnt_reg <= wdog_clear ? '0 : wdog_cnt_reg + 1'b1;
      keypad_irq       <= irq_next;
      stop_wake        <= (state_reg == SWT_STOP) && stop_mode && irq_next;
      main_clock_off   <= stop_mode && !osc_keep_in_stop;
      recovery_done    <= (state_reg == SWT_RECOVER) && (state_next == SWT_RUN);
      watchdog_timeout <= !wdog_clear && (wdog_cnt_reg == wdog_limit - 1'b1);
      wake_clock_select <= osc_keep_in_stop;
    end
  end

  // Reset-pin bit survives ordinary resets; power-on clears it
  always_ff @(posedge clk) begin
    if (rst && power_on_reset) begin
      cfg2_reg <= `SWT_CFG_RESET;
    end else if (rst) begin
      cfg2_reg <= cfg2_reg & (8'h01 << `SWT_CFG2_RSTPIN_BIT);
    end else if (c2_write) begin
      cfg2_reg <= req.dat[7:0];
    end
  end

endmodule : swt_wakeup_timer

`default_nettype wire

// >>> tb/swt_cpu_model.sv
// Processor side model: enters stop on request and leaves it on a wakeup
`timescale 1ns/1ps
`default_nettype none

module swt_cpu_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Bench control
  input  wire logic       enter,
  input  wire logic       leave,
  // Device side
  input  wire logic       stop_wake,
  output logic            stop_mode,
  output logic [7:0]      wake_count
);
  always_ff @(posedge clk) begin
    if (rst) begin
      stop_mode  <= 1'h0;
      wake_count <= 8'h00;
    end else begin
      if (stop_wake) wake_count <= wake_count + 8'h01;
      if (stop_wake || leave) stop_mode <= 1'h0;
      else if (enter) stop_mode <= 1'h1;
    end
  end
endmodule : swt_cpu_model

`default_nettype wire

// >>> tb/swt_wakeup_timer_assertions.sv
// Port checker of the wakeup timer
`include "swt_params.svh"
`timescale 1ns/1ps
`default_nettype none

module swt_wakeup_timer_assertions (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Device context and outputs
  input wire logic        stop_mode,
  input wire logic        keypad_irq,
  input wire logic        stop_wake,
  input wire logic        main_clock_off,
  input wire logic        recovery_done,
  input wire logic        wake_clock_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==================================================
  // Shadow of the written control bits
  logic mask_reg, keep_reg, srec_reg, lock1_reg, lock2_reg;
  wire logic wr_hit = wb_ack_o && wb_we_i;
  wire logic wr_c1  = wr_hit && wb_adr_i == `SWT_OFF_CFG1 && !lock1_reg;
  wire logic wr_c2  = wr_hit && wb_adr_i == `SWT_OFF_CFG2 && !lock2_reg;
  wire logic wr_ack = wr_hit && wb_adr_i == `SWT_OFF_KBD_SC && wb_dat_i[2];
  always_ff @(posedge clk) begin
    if (rst) begin
      {mask_reg, keep_reg, srec_reg, lock1_reg, lock2_reg} <= 5'h00;
    end else begin
      if (wr_hit && wb_adr_i == `SWT_OFF_KBD_SC) mask_reg <= wb_dat_i[1];
      if (wr_c1) srec_reg <= wb_dat_i[3];
      if (wr_c2) keep_reg <= wb_dat_i[1];
      lock1_reg <= lock1_reg | wr_c1;
      lock2_reg <= lock2_reg | wr_c2;
    end
  end
  // ==================================================
  // Properties
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  property p_sc_read;
    wb_ack_o && !wb_we_i && wb_adr_i == `SWT_OFF_KBD_SC |-> wb_dat_o[7:4] == 4'h0 && !wb_dat_o[2];
  endproperty
  property p_mask; mask_reg |-> !keypad_irq && !stop_wake; endproperty
  property p_ack_clear; wr_ack |-> ##[1:2] !keypad_irq; endproperty
  property p_idle; !stop_mode && !$past(stop_mode) |-> !stop_wake; endproperty
  property p_clk_off; stop_mode == $past(stop_mode) |-> main_clock_off == (stop_mode && !keep_reg);
  endproperty
  property p_src; stop_mode && $past(stop_mode) |-> wake_clock_select == keep_reg; endproperty
  property p_recover; stop_wake && srec_reg |-> ##[30:34] recovery_done; endproperty
  property p_wake_irq; stop_wake |-> ##[0:2] keypad_irq; endproperty
  a_ack: assert property (p_ack) else $error("bus answer not a single pulse");
  a_sc_read: assert property (p_sc_read) else $error("status unused bits not zero");
  a_mask: assert property (p_mask) else $error("masked request reached processor");
  a_ack_clear: assert property (p_ack_clear) else $error("acknowledge left request");
  a_idle: assert property (p_idle) else $error("wakeup outside stop");
  a_clk_off: assert property (p_clk_off) else $error("main clock state wrong");
  a_src: assert property (p_src) else $error("wake clock source wrong");
  a_recover: assert property (p_recover) else $error("short recovery time wrong");
  a_wake_irq: assert property (p_wake_irq) else $error("wake not on shared request");
  c_wake: cover property (stop_wake);
  c_recover: cover property (recovery_done && srec_reg);
  c_masked: cover property (mask_reg && stop_mode);
endmodule : swt_wakeup_timer_assertions

bind swt_wakeup_timer swt_wakeup_timer_assertions u_chk (.clk(clk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stop_mode(stop_mode),
  .keypad_irq(keypad_irq), .stop_wake(stop_wake), .main_clock_off(main_clock_off),
  .recovery_done(recovery_done), .wake_clock_select(wake_clock_select));

`default_nettype wire

// >>> tb/swt_wakeup_timer_bench.sv
// Self-checking bench of the stop-mode wakeup timer
`include "swt_params.svh"
`timescale 1ns/1ps
`default_nettype none

module swt_wakeup_timer_bench;
  logic        clk, ack, irq, wake, clk_off, rec_done, src_sel, stop_m;
  logic        rst = 1'h1, por = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, wait_m = 1'h0;
  logic        rc = 1'h0, dbl = 1'h0, rc_on = 1'h1, dbl_on = 1'h0, enter = 1'h0, leave = 1'h0;
  logic [7:0]  adr = 8'h00, q, wakes;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  int          miscompares = 0, checks_done = 0, cycles = 0, n;

  swt_wakeup_timer DUT (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .stop_mode(stop_m), .wait_mode(wait_m), .power_on_reset(por), .wake_rc_oscillator(rc),
    .doubled_bus_clock(dbl), .keypad_pin_request(1'h0), .watchdog_service(1'h0),
    .port_a_pins(8'hFF), .keypad_irq(irq), .stop_wake(wake), .main_clock_off(clk_off),
    .recovery_done(rec_done), .watchdog_timeout(), .wake_clock_select(src_sel));
  swt_cpu_model cpu (.clk(clk), .rst(rst), .enter(enter), .leave(leave), .stop_wake(wake),
    .stop_mode(stop_m), .wake_count(wakes));

  // ==================================================
  // Clock, wake sources and hang guard
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    rc <= rc_on ? ~rc : 1'h0;
    dbl <= dbl_on ? ~dbl : 1'h0;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  // ==================================================
  // Tasks
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'h1 && k < 20);
    q = rdat[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
    if (k >= 20) miscompares++;
    @(posedge clk);
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, string nm);
    xfer(1'h0, a, 8'h00);
    chk(nm, e, q & m);
  endtask : rd
  task automatic run_stop(input int lim);
    repeat (40) @(posedge clk);
    enter <= 1'h1;
    @(posedge clk);
    enter <= 1'h0;
    n = 0;
    while (wake !== 1'h1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : run_stop
  task automatic leave_stop;
    leave <= 1'h1;
    @(posedge clk);
    leave <= 1'h0;
    @(posedge clk);
  endtask : leave_stop
  task automatic reset_dut(input logic p);
    rst <= 1'h1;
    por <= p;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    por <= 1'h0;
    @(posedge clk);
  endtask : reset_dut

  // ==================================================
  // Test sequence
  initial begin
    reset_dut(1'h1);
    rd(`SWT_OFF_KBD_SC, 8'hFF, 8'h00, "status");
    rd(`SWT_OFF_KBD_EN, 8'hFF, 8'h00, "enable");
    rd(`SWT_OFF_PORT_A, 8'hFF, 8'hBF, "port a");
    rd(8'h40, 8'hFF, 8'h00, "unmapped");
    xfer(1'h1, `SWT_OFF_CFG1, 8'h88);
    xfer(1'h1, `SWT_OFF_CFG2, 8'h01);
    xfer(1'h1, `SWT_OFF_CFG1, 8'h00);
    rd(`SWT_OFF_CFG1, 8'h88, 8'h88, "config one");
    rd(`SWT_OFF_CFG2, 8'h03, 8'h01, "config two");
    xfer(1'h1, `SWT_OFF_KBD_EN, 8'h40);
    wait_m <= 1'h1;
    repeat (1200) @(posedge clk);
    wait_m <= 1'h0;
    rd(`SWT_OFF_PORT_A, 8'h40, 8'h00, "latch after wait");
    $display("test registers and wait done");
    run_stop(1100);
    chk("period", 8'h01, {7'h00, n >= 1015 && n <= 1040});
    rd(`SWT_OFF_PORT_A, 8'h40, 8'h40, "latch");
    rd(`SWT_OFF_KBD_SC, 8'h0F, 8'h08, "pending");
    chk("irq", 8'h01, {7'h00, irq});
    xfer(1'h1, `SWT_OFF_KBD_SC, 8'h04);
    rd(`SWT_OFF_PORT_A, 8'h40, 8'h00, "latch cleared");
    chk("irq cleared", 8'h00, {7'h00, irq});
    run_stop(600);
    leave_stop();
    run_stop(1100);
    chk("restart period", 8'h01, {7'h00, n >= 1015 && n <= 1040});
    xfer(1'h1, `SWT_OFF_KBD_SC, 8'h04);
    $display("test wakeup done");
    xfer(1'h1, `SWT_OFF_KBD_SC, 8'h02);
    run_stop(1200);
    chk("still stopped", 8'h01, {7'h00, stop_m});
    chk("masked irq", 8'h00, {7'h00, irq});
    leave_stop();
    xfer(1'h1, `SWT_OFF_KBD_EN, 8'h00);
    rd(`SWT_OFF_PORT_A, 8'h40, 8'h40, "latch unenabled");
    xfer(1'h1, `SWT_OFF_KBD_SC, 8'h06);
    rd(`SWT_OFF_KBD_SC, 8'h0F, 8'h02, "mask kept");
    xfer(1'h1, `SWT_OFF_KBD_SC, 8'h00);
    run_stop(1200);
    rd(`SWT_OFF_PORT_A, 8'h40, 8'h00, "latch disabled");
    leave_stop();
    $display("test mask and enable done");
    reset_dut(1'h0);
    rd(`SWT_OFF_CFG2, 8'h03, 8'h01, "reset pin kept");
    rd(`SWT_OFF_CFG1, 8'hFF, 8'h00, "config cleared");
    xfer(1'h1, `SWT_OFF_CFG1, 8'h80);
    xfer(1'h1, `SWT_OFF_CFG2, 8'h03);
    xfer(1'h1, `SWT_OFF_KBD_EN, 8'h40);
    rc_on <= 1'h0;
    dbl_on <= 1'h1;
    run_stop(1100);
    chk("bus clock period", 8'h01, {7'h00, n >= 1015 && n <= 1040});
    $display("test clock source done");
    stop_test();
  end
endmodule : swt_wakeup_timer_bench

`default_nettype wire
